// File: src/itw_front.sv
// Serial target front end: wake detect, bus conditions, address match,
// word address decode, command intake and watchdog.
// Assumes SCL_CLK is the bus clock from the master and SDA is open drain,
// resolved outside; the buffer and command engine sit downstream.
//
// Overview of operation
// - Asleep: only long SDA low wakes
// - SCL ignored until wake delay ends
// - Wake pulse ignored while awake
// - Data bit sampled on SCL rise
// - SDA fall with SCL high starts
// - Stop ends transfer, full command executes
// - Ninth clock: pull SDA low to acknowledge
// - Seven address bits match, then R/W
// - Group is count, packet, two-byte CRC
// - Group may span transfers; excess ignored
// - Word 0x00 resets buffer pointer
// - Word 0x01 plus stop: sleep, reset
// - Word 0x02 plus stop: idle, retain
// - Word 0x03 appends data to buffer
// - No read address ack while executing
// - Watchdog expiry forces sleep
// - Wake from idle restarts watchdog
// - Unmatched address: stay quiet on bus
// - Read nack when busy or partial
// - Nack bytes past count or buffer
`timescale 1ns/1ns
module itw_front
  import itw_pkg::*;
#(
  parameter int WHI_CYC = WAKE_HIGH_CYC,
  parameter int WD_CYC = WDOG_CYC
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic SCL_CLK,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic [6:0] BUS_ADDR,
  input wire logic CMD_DONE,
  output logic BUF_WE,
  output logic [6:0] BUF_ADDR,
  output logic [7:0] BUF_DATA,
  output logic CMD_START,
  output logic VOL_RESET,
  output logic [2:0] POWER_STATE
);

  // Reset release synchroniser
  logic rst_s_q;
  logic rst_n_q;

  // Link domain: SDA at each SCL rise and a toggle per rise
  logic lk_bit_q;
  logic lk_tgl_q;

  // Synchronised pins and toggle
  logic [2:0] sy;
  logic sda_h_q;
  logic scl_h_q;
  logic tgl_h_q;
  // Filtered levels and their previous values
  logic sda_f_q;
  logic sda_fp_q;
  logic scl_f_q;
  logic scl_fp_q;

  // Bus decode state
  itw_ph_t ph_q;
  logic [3:0] bit_q;
  logic [6:0] sh_q;
  logic ack_pend_q;
  logic oe_q;
  logic sda_o_q;
  logic pend_sleep_q;
  logic pend_idle_q;

  // Buffer intake
  logic [6:0] ptr_q;
  logic [7:0] cnt_q;
  logic we_q;
  logic [6:0] wa_q;
  logic [7:0] wd_data_q;
  logic start_q;
  logic volrst_q;

  // Power state and timers
  itw_pwr_t pwr_q;
  itw_pwr_t pwr_d;
  logic [WK_W-1:0] wk_q;
  logic [WD_W-1:0] wd_q;

  // Reset: async assert, release through two flops
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_s_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s_q <= 1'b1;
      rst_n_q <= rst_s_q;
    end
  end

  // SCL domain: SDA is stable while SCL is high, so the rise edge
  // captures the bit; the toggle flags the event to the ref domain
  always_ff @(posedge SCL_CLK or negedge NRST) begin
    if (!NRST) begin
      lk_bit_q <= 1'b0;
      lk_tgl_q <= 1'b0;
    end else begin
      lk_bit_q <= SDA_I;
      lk_tgl_q <= ~lk_tgl_q;
    end
  end

  // Bring pins and the toggle into the ref domain
  itw_sync #(.W(3)) u_sync (
    .clk(REF_CLK),
    .rst_n(rst_n_q),
    .d({SDA_I, SCL_CLK, lk_tgl_q}),
    .q(sy)
  );

  // Glitch filter: a level is taken only after two equal samples
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sda_h_q <= 1'b1;
      scl_h_q <= 1'b1;
      tgl_h_q <= 1'b0;
      sda_f_q <= 1'b1;
      sda_fp_q <= 1'b1;
      scl_f_q <= 1'b1;
      scl_fp_q <= 1'b1;
    end else begin
      sda_h_q <= sy[2];
      scl_h_q <= sy[1];
      tgl_h_q <= sy[0];
      sda_f_q <= (sy[2] == sda_h_q) ? sy[2] : sda_f_q;
      scl_f_q <= (sy[1] == scl_h_q) ? sy[1] : scl_f_q;
      sda_fp_q <= sda_f_q;
      scl_fp_q <= scl_f_q;
    end
  end

  // Bus conditions, gated off unless awake or busy
  wire bus_en = itw_bus_on(pwr_q);
  wire scl_hi = scl_f_q & scl_fp_q;
  wire start_det = bus_en & scl_hi & sda_fp_q & ~sda_f_q;
  wire stop_det = bus_en & scl_hi & ~sda_fp_q & sda_f_q;
  wire scl_fall = bus_en & scl_fp_q & ~scl_f_q;
  wire rise_ev = bus_en & (sy[0] ^ tgl_h_q);
  // The captured bit is held until the next SCL rise, long after use
  wire byte_done = rise_ev & (bit_q == BIT_LAST) & (ph_q != PH_NONE);
  wire [7:0] byte_w = {sh_q, lk_bit_q};

  // Address and data decisions
  wire addr_hit = byte_w[7:1] == BUS_ADDR;
  wire is_read = byte_w[0];
  wire awake = pwr_q == PW_AWAKE;
  wire read_ok = awake & (ptr_q == 7'h00);
  wire addr_ack = addr_hit & (is_read ? read_ok : awake);
  wire in_room = ptr_q < BUF_LEN;
  wire in_cnt = (ptr_q == 7'h00) | ({1'b0, ptr_q} < cnt_q);
  wire data_ok = awake & in_room & in_cnt;
  wire go_busy = stop_det & awake & ~pend_sleep_q & ~pend_idle_q
    & (cnt_q != 8'h00) & ({1'b0, ptr_q} >= cnt_q);

  // Acknowledge decision for the byte just completed
  logic ack_d;
  always_comb begin
    case (ph_q)
      PH_ADDR: ack_d = addr_ack;
      PH_WORD: ack_d = 1'b1;
      PH_DATA: ack_d = data_ok;
      default: ack_d = 1'b0;
    endcase
  end

  // Phase after the byte just completed
  itw_ph_t ph_n;
  always_comb begin
    case (ph_q)
      PH_ADDR: ph_n = (addr_ack & ~is_read) ? PH_WORD : PH_NONE;
      PH_WORD: ph_n = (byte_w == WA_CMD) ? PH_DATA : PH_NONE;
      PH_DATA: ph_n = PH_DATA;
      default: ph_n = PH_NONE;
    endcase
  end

  // Bit counter, shifter and phase
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ph_q <= PH_NONE;
      bit_q <= 4'h0;
      sh_q <= 7'h00;
    end else if (!bus_en || stop_det) begin
      ph_q <= PH_NONE;
      bit_q <= 4'h0;
    end else if (start_det) begin
      ph_q <= PH_ADDR;
      bit_q <= 4'h0;
    end else if (rise_ev) begin
      sh_q <= byte_w[6:0];
      bit_q <= (bit_q == BIT_ACK) ? 4'h0 : bit_q + 4'h1;
      if (byte_done) begin
        ph_q <= ph_n;
      end
    end
  end

  // Acknowledge drive: low from the fall after bit 8 to the fall after 9
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_pend_q <= 1'b0;
      oe_q <= 1'b0;
      sda_o_q <= 1'b0;
    end else if (!bus_en || start_det || stop_det) begin
      ack_pend_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (byte_done) begin
      ack_pend_q <= ack_d;
    end else if (scl_fall) begin
      ack_pend_q <= 1'b0;
      if (ack_pend_q) begin
        oe_q <= 1'b1;
      end else if (bit_q == 4'h0) begin
        oe_q <= 1'b0;
      end
    end
  end

  // Word address actions; sleep and idle wait for the stop
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_sleep_q <= 1'b0;
      pend_idle_q <= 1'b0;
    end else if (!bus_en || start_det || stop_det) begin
      pend_sleep_q <= 1'b0;
      pend_idle_q <= 1'b0;
    end else if (byte_done && ph_q == PH_WORD) begin
      pend_sleep_q <= byte_w == WA_SLEEP;
      pend_idle_q <= byte_w == WA_IDLE;
    end
  end

  // Buffer intake: first byte is the count, then append in order
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ptr_q <= 7'h00;
      cnt_q <= 8'h00;
      we_q <= 1'b0;
      wa_q <= 7'h00;
      wd_data_q <= 8'h00;
    end else begin
      we_q <= 1'b0;
      if (!bus_en || (pwr_q == PW_BUSY && CMD_DONE)) begin
        // Sleep, idle and completion all flush the intake
        ptr_q <= 7'h00;
        cnt_q <= 8'h00;
      end else if (byte_done && ph_q == PH_WORD && byte_w == WA_RESET) begin
        ptr_q <= 7'h00;
        cnt_q <= 8'h00;
      end else if (byte_done && ph_q == PH_DATA && data_ok) begin
        we_q <= 1'b1;
        wa_q <= ptr_q;
        wd_data_q <= byte_w;
        ptr_q <= ptr_q + 7'h01;
        if (ptr_q == 7'h00) begin
          cnt_q <= byte_w;
        end
      end
    end
  end

  // Power state sequencing
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PW_SLEEP, PW_IDLE: begin
        if (wk_q == WK_W'(WAKE_LOW_CYC)) begin
          pwr_d = PW_WLOW;
        end
      end
      PW_WLOW: begin
        if (sda_f_q) begin
          pwr_d = PW_WHIGH;
        end
      end
      PW_WHIGH: begin
        if (wk_q == WK_W'(WHI_CYC - 1)) begin
          pwr_d = PW_AWAKE;
        end
      end
      PW_AWAKE: begin
        if (stop_det && pend_sleep_q) begin
          pwr_d = PW_SLEEP;
        end else if (stop_det && pend_idle_q) begin
          pwr_d = PW_IDLE;
        end else if (go_busy) begin
          pwr_d = PW_BUSY;
        end
      end
      PW_BUSY: begin
        if (CMD_DONE) begin
          pwr_d = PW_AWAKE;
        end
      end
      default: pwr_d = PW_SLEEP;
    endcase
    if (wd_q == WD_W'(WD_CYC - 1)) begin
      pwr_d = PW_SLEEP;
    end
  end

  // Wake timer: low time while asleep, delay after the rising edge.
  // Nothing here looks at SDA once awake, so a new pulse does nothing.
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wk_q <= '0;
    end else if (itw_asleep(pwr_q)) begin
      wk_q <= (sda_f_q || pwr_d != pwr_q) ? '0 : wk_q + WK_W'(1);
    end else if (pwr_q == PW_WHIGH && pwr_d == PW_WHIGH) begin
      wk_q <= wk_q + WK_W'(1);
    end else begin
      wk_q <= '0;
    end
  end

  // Watchdog: runs from wake until sleep or idle; idle stops it
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wd_q <= '0;
    end else if (itw_asleep(pwr_q) || pwr_q == PW_WLOW || pwr_d == PW_SLEEP) begin
      wd_q <= '0;
    end else begin
      wd_q <= wd_q + WD_W'(1);
    end
  end

  // State and event pulses
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pwr_q <= PW_SLEEP;
      start_q <= 1'b0;
      volrst_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      start_q <= (pwr_q == PW_AWAKE) && (pwr_d == PW_BUSY);
      volrst_q <= (pwr_q != PW_SLEEP) && (pwr_d == PW_SLEEP);
    end
  end

  // Outputs straight from flops
  assign SDA_O = sda_o_q;
  assign SDA_OE = oe_q;
  assign BUF_WE = we_q;
  assign BUF_ADDR = wa_q;
  assign BUF_DATA = wd_data_q;
  assign CMD_START = start_q;
  assign VOL_RESET = volrst_q;
  assign POWER_STATE = pwr_q;

  // Checks
  sequence s_wake_rise;
    (pwr_q == PW_WLOW) && sda_f_q;
  endsequence
  sequence s_awake_entry;
    (pwr_q == PW_WHIGH) && (wk_q == '0);
  endsequence

  property p_wake;
    @(posedge REF_CLK) disable iff (!rst_n_q)
    s_wake_rise |=> s_awake_entry;
  endproperty
  a_wake: assert property (p_wake) else $error("wake rise not followed by delay");

  property p_quiet;
    @(posedge REF_CLK) disable iff (!rst_n_q)
    !itw_bus_on(pwr_q) |=> !SDA_OE && (ph_q == PH_NONE);
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus active while not awake");

  property p_no_rewake;
    @(posedge REF_CLK) disable iff (!rst_n_q)
    (pwr_q == PW_AWAKE) |=> (pwr_q != PW_WLOW) && (pwr_q != PW_WHIGH);
  endproperty
  a_no_rewake: assert property (p_no_rewake) else $error("wake while awake");

  property p_start;
    @(posedge REF_CLK) disable iff (!rst_n_q)
    start_det && !stop_det |=> (ph_q == PH_ADDR) && (bit_q == 4'h0);
  endproperty
  a_start: assert property (p_start) else $error("start not decoded");

  property p_busy;
    @(posedge REF_CLK) disable iff (!rst_n_q)
    go_busy && (wd_q != WD_W'(WD_CYC - 1)) |=> (pwr_q == PW_BUSY) && CMD_START;
  endproperty
  a_busy: assert property (p_busy) else $error("stop did not start command");

  property p_ack;
    @(posedge REF_CLK) disable iff (!rst_n_q)
    ack_pend_q && scl_fall && !start_det && !stop_det |=> SDA_OE && !SDA_O;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not driven");

  property p_nomatch;
    @(posedge REF_CLK) disable iff (!rst_n_q)
    byte_done && (ph_q == PH_ADDR) && !addr_hit |=> !ack_pend_q [*2];
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("foreign address acked");

  property p_sleep;
    @(posedge REF_CLK) disable iff (!rst_n_q)
    stop_det && pend_sleep_q && awake |=> (pwr_q == PW_SLEEP) && VOL_RESET ##1 !VOL_RESET && (ptr_q == 7'h00);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep word ignored");

  property p_idle;
    @(posedge REF_CLK) disable iff (!rst_n_q)
    stop_det && pend_idle_q && awake && (wd_q != WD_W'(WD_CYC - 1)) |=> (pwr_q == PW_IDLE) && !VOL_RESET;
  endproperty
  a_idle: assert property (p_idle) else $error("idle word ignored");

  property p_wdog;
    @(posedge REF_CLK) disable iff (!rst_n_q)
    (wd_q == WD_W'(WD_CYC - 1)) |=> (pwr_q == PW_SLEEP) && VOL_RESET;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog did not sleep");

  property p_full;
    @(posedge REF_CLK) disable iff (!rst_n_q)
    byte_done && (ph_q == PH_DATA) && !in_room |=> !ack_pend_q && !BUF_WE;
  endproperty
  a_full: assert property (p_full) else $error("byte past buffer acked");

endmodule : itw_front

// File: src/itw_pkg.sv
// Shared constants and types for the serial target wake/command front end.
// Assumes a 20 MHz reference clock; all timing counts derive from it.
package itw_pkg;

  // Reference clock rate in MHz
  localparam int CLK_MHZ = 20;

  // Wake low time in microseconds (SDA must stay low longer than this)
  localparam int WAKE_LOW_US = 60;
  // Least time, rounded up to whole cycles
  localparam int WAKE_LOW_CYC = (WAKE_LOW_US * CLK_MHZ * 1000 + 999) / 1000;
  // Wake high delay in microseconds before the bus is honoured
  localparam int WAKE_HIGH_US = 1500;
  // Longest time, rounded down; used as a top-level parameter default
  localparam int WAKE_HIGH_CYC = (WAKE_HIGH_US * CLK_MHZ * 1000) / 1000;
  // Watchdog interval in milliseconds
  localparam int WDOG_MS = 1300;
  // Watchdog count; used as a top-level parameter default
  localparam int WDOG_CYC = WDOG_MS * 1000 * CLK_MHZ;

  // Counter widths
  localparam int WK_W = 16;
  localparam int WD_W = 25;

  // Input buffer size in bytes
  localparam logic [6:0] BUF_LEN = 7'h47;
  // Last bit index of a byte and the acknowledge bit index
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // Word address codes
  localparam logic [7:0] WA_RESET = 8'h00;
  localparam logic [7:0] WA_SLEEP = 8'h01;
  localparam logic [7:0] WA_IDLE = 8'h02;
  localparam logic [7:0] WA_CMD = 8'h03;

  // Power states, Gray coded along sleep, wake, awake, busy
  typedef enum logic [2:0] {
    PW_SLEEP = 3'h0,
    PW_WLOW = 3'h1,
    PW_WHIGH = 3'h3,
    PW_AWAKE = 3'h2,
    PW_BUSY = 3'h6,
    PW_IDLE = 3'h4
  } itw_pwr_t;

  // Transaction phases, Gray coded
  typedef enum logic [1:0] {
    PH_NONE = 2'h0,
    PH_ADDR = 2'h1,
    PH_WORD = 2'h3,
    PH_DATA = 2'h2
  } itw_ph_t;

  // Bus conditions are honoured only when awake or busy
  function automatic logic itw_bus_on(input itw_pwr_t p);
    itw_bus_on = (p == PW_AWAKE) || (p == PW_BUSY);
  endfunction : itw_bus_on

  // Low-power states that listen only for the wake pulse
  function automatic logic itw_asleep(input itw_pwr_t p);
    itw_asleep = (p == PW_SLEEP) || (p == PW_IDLE);
  endfunction : itw_asleep

endpackage : itw_pkg

// File: src/itw_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no bus coherency is implied.
`timescale 1ns/1ns
module itw_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // First stage, read only by the second stage
  logic [W-1:0] meta_q;

  // Two flip-flops in series
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : itw_sync

// File: tb/itw_host.sv
// Host bus master model driving SCL and the host side of SDA.
// Assumes SDA is resolved outside with a pull-up; SCL idles high between frames.
`timescale 1ns/1ns
module itw_host #(
  parameter int Q_NS = 300
) (
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  // Both lines released until the first frame
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Start: SDA falls while SCL is high
  task automatic start_c();
    sda_rel = 1'b1;
    #Q_NS scl = 1'b1;
    #Q_NS sda_rel = 1'b0;
    #Q_NS scl = 1'b0;
    #Q_NS;
  endtask : start_c

  // One bit; SDA moves a quarter after the SCL fall so the target's ack release lands first
  task automatic bit_c(input logic b, output logic r);
    sda_rel = b;
    #Q_NS scl = 1'b1;
    #Q_NS r = sda;
    #Q_NS scl = 1'b0;
    #Q_NS;
  endtask : bit_c

  // Byte MSB first, then the ninth clock with SDA released
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(b[i], r);
    end
    bit_c(1'b1, ack);
  endtask : send

  // Stop: SDA rises while SCL is high, then the bus stays idle
  task automatic stop_c();
    sda_rel = 1'b0;
    #Q_NS scl = 1'b1;
    #Q_NS sda_rel = 1'b1;
    #(2 * Q_NS);
  endtask : stop_c

  // Wake: SDA held low for the given time while SCL stands high
  task automatic wake_c(input int t_ns);
    sda_rel = 1'b0;
    #t_ns sda_rel = 1'b1;
    #Q_NS;
  endtask : wake_c
endmodule : itw_host

// File: tb/tb_itw_front.sv
// Self-checking bench: host model on the bus, reference model in integers and queues.
// Assumes a 20 MHz reference clock; wake delay and watchdog are shortened by parameter.
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_itw_front
  import itw_pkg::*;
();
  localparam int WHI = 20; // Short wake delay keeps the run brief
  localparam int WD = 20000; // Long enough for the full-buffer wake session
  logic ref_clk, nrst, cmd_done;
  logic [6:0] bus_addr, tgt; // Programmed address and the one the host calls
  wire scl, sda_rel, sda_o, sda_oe, buf_we, cmd_start, vol_reset;
  wire [6:0] buf_addr;
  wire [7:0] buf_data;
  wire [2:0] pwr;
  // Open-drain wire: low if either party pulls, pull-up otherwise
  wire sda = sda_rel & ~(sda_oe & ~sda_o);
  itw_pwr_t mst; // Model power state
  int mptr, mcnt, mcmd, mvol, cmd_cnt, vol_cnt, n;
  int error_cnt = 0;
  int total_checks = 0;
  logic [14:0] got_q[$], exp_q[$]; // Buffer writes {index, byte}
  logic [7:0] q[$], e_q[$];

  itw_front #(.WHI_CYC(WHI), .WD_CYC(WD)) i_itw_front (.REF_CLK(ref_clk), .NRST(nrst), .SCL_CLK(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .BUS_ADDR(bus_addr), .CMD_DONE(cmd_done),
    .BUF_WE(buf_we), .BUF_ADDR(buf_addr), .BUF_DATA(buf_data), .CMD_START(cmd_start),
    .VOL_RESET(vol_reset), .POWER_STATE(pwr));
  itw_host u_host (.scl(scl), .sda_rel(sda_rel), .sda(sda));

  // Reference clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Collect one-cycle pulses mid-cycle, well away from the edge that launches them
  always @(negedge ref_clk) begin
    if (buf_we === 1'b1) got_q.push_back({buf_addr, buf_data});
    if (cmd_start === 1'b1) cmd_cnt++;
    if (vol_reset === 1'b1) vol_cnt++;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : cyc

  // Compare state, buffer writes and pulse counts with the model
  task automatic settle();
    logic [14:0] g, e;
    cyc(12);
    `CHK(pwr, mst)
    `CHK(sda_oe, 1'b0)
    `CHK(sda_o, 1'b0)
    `CHK(got_q.size(), exp_q.size())
    while (got_q.size() > 0 && exp_q.size() > 0) begin
      g = got_q.pop_front();
      e = exp_q.pop_front();
      `CHK(g, e)
    end
    got_q.delete();
    exp_q.delete();
    `CHK(cmd_cnt, mcmd)
    `CHK(vol_cnt, mvol)
  endtask : settle

  // Write transfer: start, address, word, data, stop; the model predicts every ack
  task automatic wr(input logic [7:0] wa, input logic [7:0] d[$]);
    logic a, hit, ok;
    u_host.start_c();
    u_host.send({tgt, 1'b0}, a);
    hit = (tgt == bus_addr) && (mst == PW_AWAKE);
    `CHK(a, !hit)
    if (hit) begin
      u_host.send(wa, a);
      `CHK(a, 1'b0)
      foreach (d[i]) begin
        ok = (wa == WA_CMD) && (mptr == 0 || mptr < mcnt) && mptr < int'(BUF_LEN);
        u_host.send(d[i], a);
        `CHK(a, !ok)
        if (ok) begin
          if (mptr == 0) mcnt = d[i];
          exp_q.push_back({7'(mptr), d[i]});
          mptr++;
        end
      end
    end
    u_host.stop_c();
    if (hit && wa == WA_RESET) mptr = 0;
    if (hit && (wa == WA_SLEEP || wa == WA_IDLE)) begin
      mst = (wa == WA_SLEEP) ? PW_SLEEP : PW_IDLE;
      mvol += (wa == WA_SLEEP);
      mptr = 0;
    end
    if (hit && wa == WA_CMD && mptr > 0 && mptr >= mcnt) begin
      mst = PW_BUSY;
      mcmd++;
    end
    settle();
  endtask : wr

  // Read address only; ack only when awake with no partial command
  task automatic rd();
    logic a;
    u_host.start_c();
    u_host.send({bus_addr, 1'b1}, a);
    u_host.stop_c();
    `CHK(a, !(mst == PW_AWAKE && mptr == 0))
  endtask : rd

  // Wake pulse longer than the wake low time, then the wake delay
  task automatic wake();
    u_host.wake_c(1300 * 50);
    if (mst == PW_SLEEP || mst == PW_IDLE) mst = PW_AWAKE;
    cyc(WHI + 40);
    `CHK(pwr, mst)
  endtask : wake

  // Command engine completion, one cycle
  task automatic done_cmd();
    cmd_done = 1'b1;
    cyc(1);
    cmd_done = 1'b0;
    mst = PW_AWAKE;
    mptr = 0;
    mcnt = 0;
    settle();
  endtask : done_cmd

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, well past the expected run of about 52000 cycles
  initial begin
    #(90000 * 50);
    error_cnt++;
    wrap_up();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    cmd_done = 1'b0;
    void'($urandom(32'ha24d));
    bus_addr = 7'($urandom());
    tgt = bus_addr;
    mst = PW_SLEEP;
    {mptr, mcnt, mcmd, mvol, cmd_cnt, vol_cnt} = '0;
    cyc(10);
    nrst = 1'b1;
    cyc(3);
    q = {8'h03, 8'($urandom())};
    wr(WA_CMD, q);
    $display("test asleep done");
    wake();
    rd();
    tgt = bus_addr ^ 7'(1 << ($urandom() % 7));
    wr(WA_CMD, q);
    tgt = bus_addr;
    wake();
    wr(WA_IDLE, e_q);
    wr(WA_CMD, q);
    $display("test wake idle done");
    wake();
    n = 3 + $urandom() % 6;
    q = {8'(n), 8'($urandom())};
    wr(WA_CMD, q);
    rd();
    q.delete();
    repeat (n - 1) q.push_back(8'($urandom()));
    wr(WA_CMD, q);
    rd();
    wr(WA_CMD, q);
    done_cmd();
    $display("test command done");
    q = {8'h05, 8'($urandom())};
    wr(WA_CMD, q);
    wr(WA_RESET, e_q);
    rd();
    q = {8'h03, 8'($urandom()), 8'($urandom())};
    wr(WA_CMD, q);
    done_cmd();
    wr(WA_SLEEP, e_q);
    $display("test reset sleep done");
    wake();
    q = {8'(72 + $urandom() % 184)};
    repeat (71) q.push_back(8'($urandom()));
    wr(WA_CMD, q);
    wr(WA_SLEEP, e_q);
    $display("test buffer full done");
    wake();
    cyc(WD - 400);
    `CHK(pwr, PW_AWAKE)
    cyc(600);
    mst = PW_SLEEP;
    mvol++;
    settle();
    $display("test watchdog done");
    wrap_up();
  end
endmodule : tb_itw_front
